// File: shared/mrd_cfg.svh
`ifndef MRD_CFG_SVH
`define MRD_CFG_SVH

// mode register addresses on the command bus
`define MRD_MA_FEATURE_ONE    6'h01
`define MRD_MA_LATENCY        6'h02
`define MRD_MA_IO_CONFIG      6'h03
`define MRD_MA_TERMINATION    6'h0b
`define MRD_MA_CA_REFERENCE   6'h0c
`define MRD_MA_REG_CONTROL    6'h0d
`define MRD_MA_DQ_REFERENCE   6'h0e

// storage slots
`define MRD_IDX_FEATURE_ONE   3'h0
`define MRD_IDX_LATENCY       3'h1
`define MRD_IDX_IO_CONFIG     3'h2
`define MRD_IDX_TERMINATION   3'h3
`define MRD_IDX_CA_REFERENCE  3'h4
`define MRD_IDX_REG_CONTROL   3'h5
`define MRD_IDX_DQ_REFERENCE  3'h6
`define MRD_NUM_REGS          7

// power-up defaults, whole bytes, undocumented bits zero
`define MRD_RST_FEATURE_ONE   8'h00
`define MRD_RST_LATENCY       8'h00
`define MRD_RST_IO_CONFIG     8'h00
`define MRD_RST_TERMINATION   8'h00
`define MRD_RST_CA_REFERENCE  8'h4d
`define MRD_RST_REG_CONTROL   8'h00
`define MRD_RST_DQ_REFERENCE  8'h4d

// field positions
`define MRD_OP_SETPOINT_BIT   7
`define MRD_WR_SETPOINT_BIT   6
`define MRD_WR_LAT_SET_BIT    6
`define MRD_WR_LAT_MSB        5
`define MRD_WR_LAT_LSB        3
`define MRD_RD_LAT_MSB        2
`define MRD_RD_LAT_LSB        0
`define MRD_WR_REC_MSB        6
`define MRD_WR_REC_LSB        4
`define MRD_WR_INV_BIT        7
`define MRD_RD_INV_BIT        6
`define MRD_CMD_TERM_MSB      6
`define MRD_CMD_TERM_LSB      4
`define MRD_DATA_TERM_MSB     2
`define MRD_DATA_TERM_LSB     0
`define MRD_VREF_RANGE_BIT    6
`define MRD_VREF_VAL_MSB      5
`define MRD_VREF_VAL_LSB      0
// reference registers keep bit 7 reserved as zero
`define MRD_VREF_WMASK        8'h7f

`endif

// File: shared/mrd_pkg.sv
package mrd_pkg;
    typedef enum logic [0:0] {
        MRD_ST_INIT,
        MRD_ST_READY
    } mrd_state_e;

    typedef logic [7:0] mrd_byte_t;
    typedef logic [2:0] mrd_idx_t;
    typedef logic [5:0] mrd_addr_t;
endpackage

// File: shared/mrd_if.sv
`timescale 1ns/1ns
// address lookup between the register core and its decoder
interface mrd_dec_if;
    mrd_pkg::mrd_addr_t addr;
    logic               hit;
    mrd_pkg::mrd_idx_t  idx;
    logic               readable;

    modport core (output addr, input hit, input idx, input readable);
    modport dec  (input addr, output hit, output idx, output readable);
endinterface

// File: logic/mrd_addr_decode.sv
`timescale 1ns/1ns
`include "mrd_cfg.svh"

module mrd_addr_decode (
    mrd_dec_if.dec dif
);
    // address to slot; unknown addresses give no hit
    always_comb begin
        dif.hit      = 1'b1;
        dif.readable = 1'b0;
        dif.idx      = `MRD_IDX_FEATURE_ONE;
        if (dif.addr == `MRD_MA_FEATURE_ONE) begin
            dif.idx = `MRD_IDX_FEATURE_ONE;
        end else if (dif.addr == `MRD_MA_LATENCY) begin
            dif.idx = `MRD_IDX_LATENCY;
        end else if (dif.addr == `MRD_MA_IO_CONFIG) begin
            dif.idx = `MRD_IDX_IO_CONFIG;
        end else if (dif.addr == `MRD_MA_TERMINATION) begin
            dif.idx = `MRD_IDX_TERMINATION;
        end else if (dif.addr == `MRD_MA_CA_REFERENCE) begin
            dif.idx      = `MRD_IDX_CA_REFERENCE;
            dif.readable = 1'b1;
        end else if (dif.addr == `MRD_MA_REG_CONTROL) begin
            dif.idx = `MRD_IDX_REG_CONTROL;
        end else if (dif.addr == `MRD_MA_DQ_REFERENCE) begin
            dif.idx      = `MRD_IDX_DQ_REFERENCE;
            dif.readable = 1'b1;
        end else begin
            dif.hit = 1'b0;
        end
    end
endmodule // mrd_addr_decode

// File: logic/mrd_mode_regs.sv
`timescale 1ns/1ns
`include "mrd_cfg.svh"
// Functional notes
// - load all listed defaults before any write
// - setpoint select bits reset to zero
// - latency set, latencies, recovery reset zero
// - both inversion enables reset off
// - both terminations reset disabled

module mrd_mode_regs (
    input  wire logic               ref_clk,
    input  wire logic               reset,
    input  wire logic               mrw_valid,
    input  wire logic               mrr_valid,
    input  wire mrd_pkg::mrd_addr_t mr_addr,
    input  wire mrd_pkg::mrd_byte_t mr_wdata,
    output logic                    mrr_data_valid,
    output mrd_pkg::mrd_byte_t      mrr_data,
    output logic                    init_done,
    output logic                    operating_setpoint_select,
    output logic                    write_setpoint_select,
    output logic                    write_latency_set_select,
    output logic [2:0]              write_latency,
    output logic [2:0]              read_latency,
    output logic [2:0]              write_recovery_count,
    output logic                    write_inversion_enable,
    output logic                    read_inversion_enable,
    output logic [2:0]              command_termination,
    output logic [2:0]              data_termination,
    output logic                    command_reference_range,
    output logic [5:0]              command_reference_level,
    output logic                    data_reference_range,
    output logic [5:0]              data_reference_level
);

    ////////////////////////////////////////////////////////////////////////
    // storage and decode

    mrd_pkg::mrd_state_e state_q;
    mrd_pkg::mrd_state_e state_d;
    mrd_pkg::mrd_byte_t  regs_q [`MRD_NUM_REGS];
    mrd_pkg::mrd_byte_t  regs_d [`MRD_NUM_REGS];
    logic                rvld_q;
    logic                rvld_d;
    mrd_pkg::mrd_byte_t  rdata_q;
    mrd_pkg::mrd_byte_t  rdata_d;

    mrd_dec_if dif ();

    // one decoder serves both commands; the controller never issues both at once
    assign dif.addr = mr_addr;

    mrd_addr_decode u_dec (
        .dif (dif)
    );

    // default byte of each slot
    function automatic mrd_pkg::mrd_byte_t reset_value(input mrd_pkg::mrd_idx_t i);
        mrd_pkg::mrd_byte_t v;
        v = 8'h00;
        case (i)
            `MRD_IDX_FEATURE_ONE:  v = `MRD_RST_FEATURE_ONE;
            `MRD_IDX_LATENCY:      v = `MRD_RST_LATENCY;
            `MRD_IDX_IO_CONFIG:    v = `MRD_RST_IO_CONFIG;
            `MRD_IDX_TERMINATION:  v = `MRD_RST_TERMINATION;
            `MRD_IDX_CA_REFERENCE: v = `MRD_RST_CA_REFERENCE;
            `MRD_IDX_REG_CONTROL:  v = `MRD_RST_REG_CONTROL;
            `MRD_IDX_DQ_REFERENCE: v = `MRD_RST_DQ_REFERENCE;
            default:               v = 8'h00;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // init sequence and register writes

    // init cycle reloads defaults, so a write racing the reset release is lost
    always_comb begin
        state_d = state_q;
        for (int i = 0; i < `MRD_NUM_REGS; i++) begin
            regs_d[i] = regs_q[i];
        end
        case (state_q)
            mrd_pkg::MRD_ST_INIT: begin
                for (int i = 0; i < `MRD_NUM_REGS; i++) begin
                    regs_d[i] = reset_value(3'(i));
                end
                state_d = mrd_pkg::MRD_ST_READY;
            end
            mrd_pkg::MRD_ST_READY: begin
                if (mrw_valid && dif.hit) begin
                    if (dif.readable) begin
                        regs_d[dif.idx] = mr_wdata & `MRD_VREF_WMASK;
                    end else begin
                        regs_d[dif.idx] = mr_wdata;
                    end
                end
            end
            default: begin
                state_d = mrd_pkg::MRD_ST_INIT;
            end
        endcase
    end

    // every bit has a reset value, documented or zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= mrd_pkg::MRD_ST_INIT;
            for (int i = 0; i < `MRD_NUM_REGS; i++) begin
                regs_q[i] <= reset_value(3'(i));
            end
        end else begin
            state_q <= state_d;
            for (int i = 0; i < `MRD_NUM_REGS; i++) begin
                regs_q[i] <= regs_d[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode register read

    // write-only and unknown addresses answer zero
    always_comb begin
        rvld_d  = mrr_valid;
        rdata_d = 8'h00;
        if (mrr_valid && dif.hit && dif.readable) begin
            rdata_d = regs_q[dif.idx];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rvld_q  <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            rvld_q  <= rvld_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field outputs, straight slices of the register flops

    assign mrr_data_valid            = rvld_q;
    assign mrr_data                  = rdata_q;
    assign init_done                 = (state_q == mrd_pkg::MRD_ST_READY);
    assign operating_setpoint_select = regs_q[`MRD_IDX_REG_CONTROL][`MRD_OP_SETPOINT_BIT];
    assign write_setpoint_select     = regs_q[`MRD_IDX_REG_CONTROL][`MRD_WR_SETPOINT_BIT];
    assign write_latency_set_select  = regs_q[`MRD_IDX_LATENCY][`MRD_WR_LAT_SET_BIT];
    assign write_latency             = regs_q[`MRD_IDX_LATENCY][`MRD_WR_LAT_MSB:`MRD_WR_LAT_LSB];
    assign read_latency              = regs_q[`MRD_IDX_LATENCY][`MRD_RD_LAT_MSB:`MRD_RD_LAT_LSB];
    assign write_recovery_count      = regs_q[`MRD_IDX_FEATURE_ONE][`MRD_WR_REC_MSB:`MRD_WR_REC_LSB];
    assign write_inversion_enable    = regs_q[`MRD_IDX_IO_CONFIG][`MRD_WR_INV_BIT];
    assign read_inversion_enable     = regs_q[`MRD_IDX_IO_CONFIG][`MRD_RD_INV_BIT];
    assign command_termination       = regs_q[`MRD_IDX_TERMINATION][`MRD_CMD_TERM_MSB:`MRD_CMD_TERM_LSB];
    assign data_termination          = regs_q[`MRD_IDX_TERMINATION][`MRD_DATA_TERM_MSB:`MRD_DATA_TERM_LSB];
    assign command_reference_range   = regs_q[`MRD_IDX_CA_REFERENCE][`MRD_VREF_RANGE_BIT];
    assign command_reference_level   = regs_q[`MRD_IDX_CA_REFERENCE][`MRD_VREF_VAL_MSB:`MRD_VREF_VAL_LSB];
    assign data_reference_range      = regs_q[`MRD_IDX_DQ_REFERENCE][`MRD_VREF_RANGE_BIT];
    assign data_reference_level      = regs_q[`MRD_IDX_DQ_REFERENCE][`MRD_VREF_VAL_MSB:`MRD_VREF_VAL_LSB];

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_release;
        $fell(reset);
    endsequence

    sequence s_init_then_ready;
        !init_done ##1 init_done;
    endsequence

    property p_init_seq;
        s_release |-> s_init_then_ready;
    endproperty
    a_init_seq: assert property (p_init_seq) else $error("init cycle not followed by ready");

    property p_setpoint_default;
        s_release |-> !operating_setpoint_select && !write_setpoint_select;
    endproperty
    a_setpoint_default: assert property (p_setpoint_default) else $error("setpoint select not zero");

    property p_latency_default;
        s_release ##1 1'b1 |-> !write_latency_set_select && write_latency == 3'h0
            && read_latency == 3'h0 && write_recovery_count == 3'h0;
    endproperty
    a_latency_default: assert property (p_latency_default) else $error("latency defaults wrong");

    property p_inversion_default;
        s_release |-> (!write_inversion_enable && !read_inversion_enable) [*2];
    endproperty
    a_inversion_default: assert property (p_inversion_default) else $error("inversion not off");

    property p_termination_default;
        s_release |-> command_termination == 3'h0 && data_termination == 3'h0;
    endproperty
    a_termination_default: assert property (p_termination_default) else $error("termination not off");

    property p_ca_ref_default;
        s_release ##1 1'b1 |-> command_reference_range && command_reference_level == 6'h0d;
    endproperty
    a_ca_ref_default: assert property (p_ca_ref_default) else $error("command reference default wrong");

    property p_dq_ref_default;
        s_release |-> data_reference_range && data_reference_level == 6'h0d
            && !init_done ##1 mrr_data_valid == $past(mrr_valid);
    endproperty
    a_dq_ref_default: assert property (p_dq_ref_default) else $error("data reference default wrong");

    property p_no_early_write;
        !init_done |=> regs_q[`MRD_IDX_LATENCY] == `MRD_RST_LATENCY
            && regs_q[`MRD_IDX_CA_REFERENCE] == `MRD_RST_CA_REFERENCE;
    endproperty
    a_no_early_write: assert property (p_no_early_write) else $error("write taken before defaults");

    property p_write_lands;
        init_done && mrw_valid && mr_addr == `MRD_MA_LATENCY |=> regs_q[`MRD_IDX_LATENCY] == $past(mr_wdata);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("latency write not stored");

    property p_readback;
        mrr_valid && mr_addr == `MRD_MA_DQ_REFERENCE && !mrw_valid
            |=> mrr_data_valid && mrr_data == regs_q[`MRD_IDX_DQ_REFERENCE];
    endproperty
    a_readback: assert property (p_readback) else $error("reference readback wrong");

endmodule // mrd_mode_regs

// File: test/mrd_ctl_model.sv
`timescale 1ns/1ns
// controller side of the command bus: issues mode register commands
module mrd_ctl_model (
    input  wire logic               ref_clk,
    input  wire logic               mrr_data_valid,
    input  wire mrd_pkg::mrd_byte_t mrr_data,
    output logic                    mrw_valid,
    output logic                    mrr_valid,
    output mrd_pkg::mrd_addr_t      mr_addr,
    output mrd_pkg::mrd_byte_t      mr_wdata
);
    // idle bus at time zero
    initial begin
        mrw_valid = 1'b0;
        mrr_valid = 1'b0;
        mr_addr   = 6'h2a;
        mr_wdata  = 8'h5a;
    end

    // one write command, taken at the second edge
    task automatic mr_write(input mrd_pkg::mrd_addr_t a, input mrd_pkg::mrd_byte_t d);
        @(posedge ref_clk);
        mrw_valid <= 1'b1;
        mr_addr   <= a;
        mr_wdata  <= d;
        @(posedge ref_clk);
        mrw_valid <= 1'b0;
        mr_addr   <= ~a; // released lines must not keep the last value
        mr_wdata  <= ~d;
        #1;
    endtask

    // one read command, answer looked at in the cycle after the taking edge
    task automatic mr_read(input mrd_pkg::mrd_addr_t a, output logic v, output mrd_pkg::mrd_byte_t d);
        @(posedge ref_clk);
        mrr_valid <= 1'b1;
        mr_addr   <= a;
        @(posedge ref_clk);
        mrr_valid <= 1'b0;
        mr_addr   <= ~a;
        #1;
        v = mrr_data_valid;
        d = mrr_data;
    endtask

    // scheduled clocks for a core timing parameter, rounded up plus derating
    function automatic int core_param_clock_count(input int t_ps, input int tck_ps, input int derate);
        core_param_clock_count = (t_ps + tck_ps - 1) / tck_ps;
        if (derate > 0) begin
            core_param_clock_count += derate;
        end
    endfunction

    // worst derating of two separately analysed parameters
    function automatic int worst_derate(input int a, input int b);
        worst_derate = (a > b) ? a : b;
    endfunction
endmodule // mrd_ctl_model

// File: test/sdram_mode_register_defaults_test.sv
`timescale 1ns/1ns
module sdram_mode_register_defaults_test;
    logic               ref_clk = 1'b0;
    logic               reset   = 1'b1;
    logic               mrw_valid, mrr_valid, mrr_data_valid, init_done;
    mrd_pkg::mrd_addr_t mr_addr;
    mrd_pkg::mrd_byte_t mr_wdata, mrr_data, rd;
    logic               op_sel, wr_sel, wr_set, wr_inv, rd_inv, ca_rng, dq_rng, v;
    logic [2:0]         wr_lat, rd_lat, wr_rec, ca_term, dq_term;
    logic [5:0]         ca_lvl, dq_lvl;
    logic [33:0]        fields;
    logic [7:0]         sh [7];
    logic [5:0]         ma [7] = '{6'h01, 6'h02, 6'h03, 6'h0b, 6'h0c, 6'h0d, 6'h0e};
    mrd_pkg::mrd_addr_t a;
    mrd_pkg::mrd_byte_t d;
    int                 k, gap, n_errors = 0, n_checks = 0, cyc = 0;

    always #20 ref_clk = ~ref_clk;

    assign fields = {op_sel, wr_sel, wr_set, wr_lat, rd_lat, wr_rec, wr_inv, rd_inv, ca_term, dq_term,
                     ca_rng, ca_lvl, dq_rng, dq_lvl};

    mrd_mode_regs mrd_mode_regs_inst (.ref_clk(ref_clk), .reset(reset), .mrw_valid(mrw_valid),
        .mrr_valid(mrr_valid), .mr_addr(mr_addr), .mr_wdata(mr_wdata), .mrr_data_valid(mrr_data_valid),
        .mrr_data(mrr_data), .init_done(init_done), .operating_setpoint_select(op_sel),
        .write_setpoint_select(wr_sel), .write_latency_set_select(wr_set), .write_latency(wr_lat),
        .read_latency(rd_lat), .write_recovery_count(wr_rec), .write_inversion_enable(wr_inv),
        .read_inversion_enable(rd_inv), .command_termination(ca_term), .data_termination(dq_term),
        .command_reference_range(ca_rng), .command_reference_level(ca_lvl),
        .data_reference_range(dq_rng), .data_reference_level(dq_lvl));

    mrd_ctl_model mrd_ctl_model_inst (.ref_clk(ref_clk), .mrr_data_valid(mrr_data_valid),
        .mrr_data(mrr_data), .mrw_valid(mrw_valid), .mrr_valid(mrr_valid), .mr_addr(mr_addr),
        .mr_wdata(mr_wdata));

    ////////////////////////////////////////////////////////////////////////////
    // shadow of the register bytes, slot order as the address table
    function automatic logic [33:0] expect_fields();
        expect_fields = {sh[5][7:6], sh[1][6:0], sh[0][6:4], sh[2][7:6], sh[3][6:4], sh[3][2:0],
                         sh[4][6:0], sh[6][6:0]};
    endfunction

    // documented power-up codes; undocumented bits chosen zero
    task automatic load_defaults();
        foreach (sh[i]) sh[i] = 8'h00;
        sh[4] = 8'h4d;
        sh[6] = 8'h4d;
    endtask

    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // hang guard, well above the few hundred cycles needed
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc >= 5000) begin
            n_errors++;
            final_report();
        end
    end

    initial begin
        void'($urandom(32'h91e5));
        load_defaults();
        // a write during reset must be dropped
        mrd_ctl_model_inst.mr_write(6'h02, 8'h3f);
        @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        check(fields === expect_fields(), "defaults in reset");
        check(init_done === 1'b0, "init_done during reset");
        // earliest legal write, at the second edge after release
        mrd_ctl_model_inst.mr_write(6'h0d, 8'hc0);
        sh[5] = 8'hc0;
        check(init_done === 1'b1 && fields === expect_fields(), "first write");
        mrd_ctl_model_inst.mr_read(6'h0c, v, rd);
        check(v === 1'b1 && rd === 8'h4d, "command reference default");
        // answer strobe must drop after one cycle and data return to zero
        @(posedge ref_clk);
        #1;
        check(mrr_data_valid === 1'b0 && mrr_data === 8'h00, "read answer stands one cycle");
        mrd_ctl_model_inst.mr_read(6'h0e, v, rd);
        check(v === 1'b1 && rd === 8'h4d, "data reference default");
        $display("test reset_defaults done");
        // random writes to every slot and to unmapped places, each read back
        for (int i = 0; i < 80; i++) begin
            // idle gap as a controller schedules it: rounded-up parameter plus worst derating
            gap = mrd_ctl_model_inst.worst_derate(int'($urandom_range(2)) - 1, int'($urandom_range(2)) - 1);
            gap = mrd_ctl_model_inst.core_param_clock_count(int'($urandom_range(120000, 1)), 40000, gap);
            repeat (gap) @(posedge ref_clk);
            k = $urandom_range(7, 0);
            d = 8'($urandom());
            a = (k == 7) ? 6'($urandom_range(63, 16)) : ma[k];
            mrd_ctl_model_inst.mr_write(a, d);
            if (k < 7) sh[k] = (k == 4 || k == 6) ? (d & 8'h7f) : d;
            check(fields === expect_fields(), "field update");
            mrd_ctl_model_inst.mr_read(a, v, rd);
            check(v === 1'b1 && rd === ((k == 4 || k == 6) ? sh[k] : 8'h00), "read answer");
        end
        $display("test random_access done");
        // second reset in mid-run restores every default; a write taken in the init cycle is lost
        @(posedge ref_clk);
        reset <= 1'b1;
        fork
            mrd_ctl_model_inst.mr_write(6'h02, 8'h3f);
            begin
                @(posedge ref_clk);
                reset <= 1'b0;
                load_defaults();
                #1;
                check(fields === expect_fields() && init_done === 1'b0, "defaults after reset");
            end
        join
        check(fields === expect_fields() && init_done === 1'b1, "write in init cycle lost");
        mrd_ctl_model_inst.mr_read(6'h0e, v, rd);
        check(v === 1'b1 && rd === 8'h4d, "data reference after reset");
        $display("test second_reset done");
        final_report();
    end
endmodule // sdram_mode_register_defaults_test
